// ==== bench/ide_engine_monitor.sv ====
// port-level timing checks for the command-record engine
// assumes one clock domain; attached by the bind at the foot
module ide_engine_monitor
  import ide_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sym_valid,
  input wire logic sym_ready,
  input wire logic asym_valid,
  input wire logic asym_ready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic dp_start,
  input wire logic dp_cipher_en,
  input wire logic [1:0] dp_auth_sel,
  input wire logic dp_req,
  input wire logic dp_dig,
  input wire logic [31:0] dp_wdata,
  input wire logic dp_cipher_word,
  input wire logic dp_ack,
  input wire logic rec_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // a taken address starts the header read at once
  a_sym_take: assert property (sym_ready |-> $past(sym_valid) && mem_req && !mem_we)
    else $error("sym ready without request or header read");
  // the symmetric queue wins when both wait
  a_asym_take: assert property (asym_ready |-> $past(asym_valid) && !$past(sym_valid) && mem_req)
    else $error("asym ready out of turn");
  a_ready_pulse: assert property ((sym_ready || asym_ready) |=> !sym_ready && !asym_ready)
    else $error("ready longer than one cycle");
  // an access is held whole until its acknowledge
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
    && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("unaligned memory access");
  // no datapath start for an illegal flag mix
  a_start_legal: assert property (dp_start |=> (dp_cipher_en || dp_auth_sel != AUTH_NONE)
    && dp_auth_sel != 2'h3)
    else $error("datapath started with illegal flags");
  a_dig_hold: assert property (dp_dig && !dp_ack |=> dp_dig)
    else $error("digest request dropped early");
  a_dp_hold: assert property (dp_req && !dp_ack |=> dp_req && $stable(dp_wdata) && $stable(dp_cipher_word))
    else $error("data request changed before ack");
  // the header write is the last access of a record; a new one may be taken right after
  a_done_last: assert property (rec_done |-> !mem_req && !dp_req ##1 !rec_done)
    else $error("activity right after record done");
endmodule : ide_engine_monitor

bind ide_engine ide_engine_monitor u_mon (.mclk(mclk), .rst_b(rst_b), .sym_valid(sym_valid),
  .sym_ready(sym_ready), .asym_valid(asym_valid), .asym_ready(asym_ready), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .dp_start(dp_start),
  .dp_cipher_en(dp_cipher_en), .dp_auth_sel(dp_auth_sel), .dp_req(dp_req), .dp_dig(dp_dig),
  .dp_wdata(dp_wdata), .dp_cipher_word(dp_cipher_word), .dp_ack(dp_ack), .rec_done(rec_done));

// ==== bench/ide_engine_tb_top.sv ====
// self-checking bench: records built in model memory, run through the queues
// assumes the host model answers memory and datapath requests
module ide_engine_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ide_pkg::*;
  localparam logic [31:0] DIG = 32'h5EED_0000; // digest pattern of the model
  logic mclk, rst_b, sym_valid, sym_ready, asym_valid, asym_ready;
  logic mem_req, mem_we, mem_ack, dp_start, dp_cipher_en, dp_inbound, dp_req, dp_dig, dp_ack, rec_done;
  logic [31:0] symmetric_queue_address, asymmetric_queue_address, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] dp_wdata, dp_rdata;
  logic [1:0] dp_auth_sel;
  logic ctx_valid;
  logic [5:0] ctx_index;
  logic [31:0] ctx_word, key_q; // first key word seen on the context port
  int fails, n_checks, cyc;
  logic [8:0] tbl [8]; // queue and opcode of the decode sweep
  logic [7:0] bad; // which sweep entries must fail
  ide_engine uut (.mclk(mclk), .rst_b(rst_b), .sym_valid(sym_valid),
    .symmetric_queue_address(symmetric_queue_address), .sym_ready(sym_ready), .asym_valid(asym_valid),
    .asymmetric_queue_address(asymmetric_queue_address), .asym_ready(asym_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ctx_valid(ctx_valid), .ctx_index(ctx_index), .ctx_word(ctx_word), .dp_start(dp_start),
    .dp_cipher_en(dp_cipher_en), .dp_inbound(dp_inbound), .dp_auth_sel(dp_auth_sel), .dp_req(dp_req),
    .dp_dig(dp_dig),
    .dp_wdata(dp_wdata), .dp_cipher_word(), .dp_ack(dp_ack), .dp_rdata(dp_rdata), .busy(),
    .rec_done(rec_done));
  ide_host_model #(.DIG_BASE(DIG)) u_host (.mclk(mclk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .dp_start(dp_start), .dp_req(dp_req), .dp_dig(dp_dig), .dp_wdata(dp_wdata), .dp_ack(dp_ack),
    .dp_rdata(dp_rdata));
  function automatic logic [31:0] rd(input logic [31:0] a);
    return u_host.mem[a[11:2]];
  endfunction : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_host.mem[a[11:2]] = d;
  endtask : wr
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // packet descriptor: context, input entry, output entry, packet length
  task automatic desc(input logic [31:0] b, c, ia, inx, il, oa, onx, ol, pl);
    wr(b, c);
    wr(b + 32'h4, ia);
    wr(b + 32'h8, inx);
    wr(b + 32'hC, il);
    wr(b + 32'h10, oa);
    wr(b + 32'h14, onx);
    wr(b + 32'h18, ol);
    wr(b + 32'h1C, pl);
  endtask : desc
  // hand a record address to one queue, hold it until taken, wait for done
  task automatic run(input logic asy, input logic [31:0] hdr);
    u_host.ctx_rd = 0;
    @(negedge mclk);
    symmetric_queue_address = hdr;
    asymmetric_queue_address = hdr;
    sym_valid = !asy;
    asym_valid = asy;
    while (sym_ready !== 1'b1 && asym_ready !== 1'b1) @(negedge mclk);
    sym_valid = 1'b0;
    asym_valid = 1'b0;
    while (rec_done !== 1'b1) @(negedge mclk);
  endtask : run
  task automatic dig(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) chk(DIG + i, rd(b + 4 * i));
  endtask : dig
  // one-descriptor record at 0x1C0, single input entry, output length from offset
  task automatic one(input logic asy, input logic [31:0] w0, w1, pl, il, hx);
    wr(32'h1C0, 32'h0000_0001);
    desc(32'h1C4, 32'h280, 32'h300, 32'h0, il, 32'h400, 32'h500, pl - {16'h0, w1[29:16], 2'h0}, pl);
    wr(32'h280, w0);
    wr(32'h284, w1);
    run(asy, 32'h1C0);
    chk(hx, rd(32'h1C0));
  endtask : one
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin // 200 MHz clock
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin // hang guard, well above the run length
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  // catch the first key word on its pulse
  always @(posedge mclk) if (ctx_valid && ctx_index == 6'h2) key_q <= ctx_word;
  initial begin
    rst_b = 1'b0;
    sym_valid = 1'b0;
    asym_valid = 1'b0;
    symmetric_queue_address = 32'h0;
    asymmetric_queue_address = 32'h0;
    tbl = '{9'h005, 9'h040, 9'h006, 9'h101, 9'h147, 9'h149, 9'h100, 9'h148};
    bad = 8'b1100_0100;
    for (int i = 0; i < 1024; i++) u_host.mem[i] = 32'hA5A5_0000 + i;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    // outbound 3des + sha1, offset one word
    one(1'b0, 32'h0000_0050, 32'h0001_A000, 32'hC, 32'hC, 32'h0001_0001);
    chk(~rd(32'h304), rd(32'h400));
    chk(~rd(32'h308), rd(32'h404));
    chk(32'hA5A5_0102, rd(32'h408));
    dig(32'h500, 5);
    chk(32'hA, {28'h0, dp_cipher_en, dp_inbound, dp_auth_sel});
    chk(32'h14, 32'(u_host.ctx_rd));
    chk(rd(32'h288), key_q);
    $display("test des_sha1_out done");
    // bad opcode, then inbound 3des + md5 over two-entry chains
    wr(32'h140, 32'h0000_0002);
    desc(32'h144, 32'h280, 32'h300, 32'h0, 32'h8, 32'h400, 32'h500, 32'h8, 32'h8);
    wr(32'h280, 32'h0600_0010);
    desc(32'h164, 32'h200, 32'h300, 32'h600, 32'h8, 32'h400, 32'h60C, 32'h8, 32'h10);
    wr(32'h200, 32'h0000_0050);
    wr(32'h204, 32'h0000_D000);
    desc(32'h600, 32'h310, 32'h0, 32'h8, 32'h440, 32'h540, 32'h8, 32'h0, 32'h0);
    run(1'b0, 32'h140);
    chk(32'h1003_0002, rd(32'h140));
    chk(32'h10, 32'(u_host.ctx_rd));
    for (int i = 0; i < 2; i++) chk(~rd(32'h300 + 4 * i), rd(32'h400 + 4 * i));
    for (int i = 0; i < 2; i++) chk(~rd(32'h310 + 4 * i), rd(32'h440 + 4 * i));
    dig(32'h540, 4);
    chk(32'hA5A5_0154, rd(32'h550));
    chk(32'hD, {28'h0, dp_cipher_en, dp_inbound, dp_auth_sel});
    $display("test chains_in done");
    // opcode sweep over both queues
    for (int i = 0; i < 8; i++) one(tbl[i][8], {tbl[i][7:0], 24'h40}, 32'h1000, 32'h8, 32'h8,
      bad[i] ? 32'h1003_0001 : 32'h0001_0001);
    $display("test opcodes done");
    // illegal flag mixes and a short input chain
    one(1'b0, 32'h0000_0050, 32'h0000_3000, 32'h8, 32'h8, 32'h1003_0001);
    one(1'b0, 32'h0000_0050, 32'h0000_0000, 32'h8, 32'h8, 32'h1003_0001);
    one(1'b0, 32'h0000_0050, 32'h0000_1000, 32'h10, 32'h8, 32'h5003_0001);
    $display("test errors done");
    // sha1 only: digest at descriptor output next, buffer untouched
    for (int i = 0; i < 5; i++) wr(32'h500 + 4 * i, 32'h0);
    wr(32'h400, 32'h0);
    one(1'b0, 32'h0000_0050, 32'h0000_2000, 32'h8, 32'h8, 32'h0001_0001);
    dig(32'h500, 5);
    chk(32'h0, rd(32'h400));
    $display("test auth_only done");
    results();
  end
endmodule : ide_engine_tb_top

// ==== bench/ide_host_model.sv ====
// host memory and cipher/hash datapath stand-in
// assumes a 4 KB window; the bench preloads and reads mem directly
module ide_host_model
  import ide_pkg::*;
#(
  parameter logic [31:0] DIG_BASE = 32'h5EED_0000 // arbitrary digest pattern
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic dp_start,
  input wire logic dp_req,
  input wire logic dp_dig,
  input wire logic [31:0] dp_wdata,
  output logic dp_ack,
  output logic [31:0] dp_rdata
);
  logic [31:0] mem [0:1023]; // word store
  int ctx_rd; // reads seen in 0x280..0x2FF
  logic slow_q; // alternates prompt and slow answers
  logic [1:0] wait_q; // cycles left before the next ack
  logic [2:0] dig_n; // digest words handed out
  // memory port; idle read data flips so no stale word looks valid
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      slow_q <= 1'b0;
      wait_q <= 2'h0;
    end else if (mem_req && !mem_ack && wait_q == 2'h0) begin
      mem_ack <= 1'b1;
      slow_q <= !slow_q;
      wait_q <= slow_q ? 2'h2 : 2'h0;
      mem_rdata <= mem[mem_addr[11:2]];
      if (mem_we) mem[mem_addr[11:2]] <= mem_wdata;
      if (!mem_we && mem_addr[11:7] == 5'h05) ctx_rd++;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wait_q <= wait_q - 2'h1;
    end
  end
  // datapath: processed word is the inverse, digest is a counted pattern
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dp_ack <= 1'b0;
      dp_rdata <= 32'h0;
      dig_n <= 3'h0;
    end else if ((dp_req || dp_dig) && !dp_ack) begin
      dp_ack <= 1'b1;
      dp_rdata <= dp_req ? ~dp_wdata : DIG_BASE + {29'h0, dig_n};
      if (dp_dig) dig_n <= dig_n + 3'h1;
    end else begin
      dp_ack <= 1'b0;
      dp_rdata <= ~dp_rdata;
      if (dp_start) dig_n <= 3'h0;
    end
  end
endmodule : ide_host_model

// ==== rtl/ide_engine.sv ====
// command-record engine for combined ipsec des/3des-cbc with hmac authentication
// assumes a word-wide dma port with one access in flight and an external cipher/hash datapath
// What this block does
// - symmetric opcodes 0x00..0x05, 0x40 decoded
// - asymmetric opcodes mapped, reserved ones invalid
// - set done bit 16, keep count
// - fetch at least 64 context bytes
// - md5 state uses leading 16 of 20
// - flag bit 14 selects direction
// - bit 15 cipher, bits 13:12 auth
// - first key byte in word msb
// - offset in words, cipher length subtracts it
// - first entry from descriptor, rest fetched lazily
// - authenticate whole packet, cipher from offset
// - fill output buffers until cipher length
// - write full hmac at last next pointer
// - auth-only hmac at descriptor output next
// - iv taken from the context
// - undefined opcode sets error bit, code 0001
// - short input chain reports code 0101
module ide_engine
  import ide_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  // command record queues: address of a record
  input wire logic sym_valid,
  input wire logic [31:0] symmetric_queue_address,
  output logic sym_ready,
  input wire logic asym_valid,
  input wire logic [31:0] asymmetric_queue_address,
  output logic asym_ready,
  // dma word port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // context words towards the datapath (keys, iv, hmac states)
  output logic ctx_valid,
  output logic [5:0] ctx_index,
  output logic [31:0] ctx_word,
  // cipher/hash datapath
  output logic dp_start,
  output logic dp_cipher_en,
  output logic dp_inbound,
  output logic [1:0] dp_auth_sel,
  output logic dp_req,
  output logic dp_dig,
  output logic [31:0] dp_wdata,
  output logic dp_cipher_word,
  input wire logic dp_ack,
  input wire logic [31:0] dp_rdata,
  // status
  output logic busy,
  output logic rec_done
);
  ide_state_t st_q;
  logic asym_q; // current record source
  logic [31:0] hdr_addr_q, desc_addr_q, ctx_addr_q;
  logic [15:0] npkt_q, pkt_idx_q;
  logic [5:0] wcnt_q; // word index within a fetch
  logic [15:0] ctx_len_q; // stated context length
  logic [7:0] opcode_q;
  logic [15:0] flags_q, offset_q;
  logic [31:0] in_addr_q, in_next_q, in_rem_q;
  logic [31:0] out_addr_q, out_next_q, out_rem_q;
  logic [31:0] pkt_len_q, pos_q;
  logic [31:0] res_q; // datapath result word
  logic err_q;
  logic [3:0] code_q;
  logic [1:0] op_class;
  logic cipher_en, inbound;
  logic [1:0] auth_sel;

  ide_op_decode u_dec (
    .asym(asym_q),
    .opcode(opcode_q),
    .flags(flags_q),
    .op_class(op_class),
    .cipher_en(cipher_en),
    .inbound(inbound),
    .auth_sel(auth_sel)
  );

  // named decode terms
  wire [15:0] ctx_fetch = (ctx_len_q < CTX_MIN_BYTES) ? CTX_MIN_BYTES : ctx_len_q;
  wire [5:0] ctx_last = 6'((ctx_fetch >> 2) - 16'h1);
  wire [31:0] off_bytes = {14'h0, offset_q, 2'h0};
  wire in_cipher = cipher_en && (pos_q >= off_bytes);
  wire pkt_end = (pos_q >= pkt_len_q);
  wire [2:0] dig_words = (auth_sel == AUTH_MD5) ? DIG_WORDS_MD5 : DIG_WORDS_SHA;
  wire last_pkt = (pkt_idx_q + 16'h1 == npkt_q);
  wire [31:0] hdr_out = {code_q, 10'h0, err_q, 1'b1, npkt_q};

  // one place to note a failed descriptor; first error code is kept
  function automatic logic [3:0] keep_code(input logic e, input logic [3:0] old, input logic [3:0] nw);
    keep_code = e ? old : nw;
  endfunction : keep_code

  // main sequencer; a memory access holds mem_req until its ack
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= IDE_IDLE;
      {sym_ready, asym_ready, mem_req, mem_we, ctx_valid, dp_start, dp_req, dp_dig, rec_done} <= '0;
      {mem_addr, mem_wdata, dp_wdata, res_q, hdr_addr_q, desc_addr_q, ctx_addr_q} <= '0;
      {in_addr_q, in_next_q, in_rem_q, out_addr_q, out_next_q, out_rem_q, pkt_len_q, pos_q} <= '0;
      {npkt_q, pkt_idx_q, ctx_len_q, flags_q, offset_q, opcode_q} <= '0;
      {ctx_index, ctx_word, wcnt_q, code_q} <= '0;
      {asym_q, err_q, dp_cipher_word, dp_cipher_en, dp_inbound, dp_auth_sel} <= '0;
    end else begin
      // pulses drop by default
      {sym_ready, asym_ready, ctx_valid, dp_start, rec_done} <= '0;
      case (st_q)
        IDE_IDLE: begin
          // symmetric queue first, one record at a time
          if (sym_valid) begin
            sym_ready <= 1'b1;
            asym_q <= 1'b0;
            hdr_addr_q <= symmetric_queue_address;
            mem_addr <= symmetric_queue_address;
            mem_req <= 1'b1;
            st_q <= IDE_HDR_RD;
          end else if (asym_valid) begin
            asym_ready <= 1'b1;
            asym_q <= 1'b1;
            hdr_addr_q <= asymmetric_queue_address;
            mem_addr <= asymmetric_queue_address;
            mem_req <= 1'b1;
            st_q <= IDE_HDR_RD;
          end
        end
        IDE_HDR_RD: if (mem_ack) begin
          // count of at least one is the host's duty
          npkt_q <= mem_rdata[HDR_NPKT_MSB:0];
          pkt_idx_q <= '0;
          {err_q, code_q} <= '0;
          desc_addr_q <= hdr_addr_q + WORD_BYTES;
          mem_addr <= hdr_addr_q + WORD_BYTES;
          wcnt_q <= '0;
          st_q <= IDE_DESC_RD;
        end
        IDE_DESC_RD: if (mem_ack) begin
          // first input and output chain entries live in the descriptor
          case (wcnt_q[3:0])
            DW_CTX: ctx_addr_q <= mem_rdata;
            DW_IN_ADDR: in_addr_q <= mem_rdata;
            DW_IN_NEXT: in_next_q <= mem_rdata;
            DW_IN_LEN: in_rem_q <= mem_rdata;
            DW_OUT_ADDR: out_addr_q <= mem_rdata;
            DW_OUT_NEXT: out_next_q <= mem_rdata;
            DW_OUT_LEN: out_rem_q <= mem_rdata;
            default: pkt_len_q <= mem_rdata;
          endcase
          if (wcnt_q[3:0] == DESC_WORDS - 4'h1) begin
            mem_addr <= ctx_addr_q;
            wcnt_q <= '0;
            ctx_len_q <= CTX_MIN_BYTES;
            st_q <= IDE_CTX_RD;
          end else begin
            mem_addr <= mem_addr + WORD_BYTES;
            wcnt_q <= wcnt_q + 6'h1;
          end
        end
        IDE_CTX_RD: if (mem_ack) begin
          // keys, iv and hmac states pass through unchanged, first byte at the msb
          if (wcnt_q == XW_HEAD) begin
            opcode_q <= mem_rdata[31:24];
            ctx_len_q <= mem_rdata[15:0];
          end else if (wcnt_q == XW_FLAGS) begin
            offset_q <= mem_rdata[31:16];
            flags_q <= mem_rdata[15:0];
          end else begin
            ctx_valid <= 1'b1;
            ctx_index <= wcnt_q;
            ctx_word <= mem_rdata;
          end
          if ((wcnt_q != XW_HEAD) && (wcnt_q >= ctx_last)) begin
            mem_req <= 1'b0;
            st_q <= IDE_DECIDE;
          end else begin
            mem_addr <= mem_addr + WORD_BYTES;
            wcnt_q <= wcnt_q + 6'h1;
          end
        end
        IDE_DECIDE: begin
          // failed or foreign commands move no data
          if (op_class == OPC_BAD) begin
            code_q <= keep_code(err_q, code_q, ERR_OPCODE);
            err_q <= 1'b1;
            st_q <= IDE_NEXT;
          end else if (op_class == OPC_OTHER) begin
            st_q <= IDE_NEXT;
          end else begin
            dp_start <= 1'b1;
            dp_cipher_en <= cipher_en;
            dp_inbound <= inbound;
            dp_auth_sel <= auth_sel;
            pos_q <= '0;
            st_q <= IDE_IN_STEP;
          end
        end
        IDE_IN_STEP: begin
          // whole packet feeds the hash; cipher words are flagged from the offset
          if (pkt_end) begin
            wcnt_q <= '0;
            st_q <= (auth_sel != AUTH_NONE) ? IDE_DIG : IDE_NEXT;
          end else if (in_rem_q == '0) begin
            if (in_next_q == '0) begin
              code_q <= keep_code(err_q, code_q, ERR_CHAIN);
              err_q <= 1'b1;
              st_q <= IDE_NEXT;
            end else begin
              mem_addr <= in_next_q;
              mem_req <= 1'b1;
              wcnt_q <= '0;
              st_q <= IDE_IN_CHAIN;
            end
          end else begin
            mem_addr <= in_addr_q;
            mem_req <= 1'b1;
            st_q <= IDE_IN_RD;
          end
        end
        IDE_IN_CHAIN, IDE_OUT_CHAIN: if (mem_ack) begin
          // fetched only when the previous buffer ran dry
          if (st_q == IDE_IN_CHAIN) begin
            if (wcnt_q[3:0] == CW_ADDR) in_addr_q <= mem_rdata;
            if (wcnt_q[3:0] == CW_NEXT) in_next_q <= mem_rdata;
            if (wcnt_q[3:0] == CW_LEN) in_rem_q <= mem_rdata;
          end else begin
            if (wcnt_q[3:0] == CW_ADDR) out_addr_q <= mem_rdata;
            if (wcnt_q[3:0] == CW_NEXT) out_next_q <= mem_rdata;
            if (wcnt_q[3:0] == CW_LEN) out_rem_q <= mem_rdata;
          end
          if (wcnt_q[3:0] == CHAIN_WORDS - 4'h1) begin
            mem_req <= 1'b0;
            st_q <= (st_q == IDE_IN_CHAIN) ? IDE_IN_STEP : IDE_OUT_WR;
          end else begin
            mem_addr <= mem_addr + WORD_BYTES;
            wcnt_q <= wcnt_q + 6'h1;
          end
        end
        IDE_IN_RD: if (mem_ack) begin
          mem_req <= 1'b0;
          dp_req <= 1'b1;
          dp_wdata <= mem_rdata;
          dp_cipher_word <= in_cipher;
          st_q <= IDE_DP_WAIT;
        end
        IDE_DP_WAIT: if (dp_ack) begin
          dp_req <= 1'b0;
          res_q <= dp_rdata;
          in_addr_q <= in_addr_q + WORD_BYTES;
          in_rem_q <= in_rem_q - WORD_BYTES;
          pos_q <= pos_q + WORD_BYTES;
          st_q <= dp_cipher_word ? IDE_OUT_WR : IDE_IN_STEP;
        end
        IDE_OUT_WR: begin
          // next output entry is read when the current buffer is full
          if (!mem_req && (out_rem_q == '0)) begin
            mem_we <= 1'b0;
            mem_addr <= out_next_q;
            mem_req <= 1'b1;
            wcnt_q <= '0;
            st_q <= IDE_OUT_CHAIN;
          end else if (!mem_req) begin
            mem_we <= 1'b1;
            mem_addr <= out_addr_q;
            mem_wdata <= res_q;
            mem_req <= 1'b1;
          end else if (mem_ack) begin
            {mem_req, mem_we} <= '0;
            out_addr_q <= out_addr_q + WORD_BYTES;
            out_rem_q <= out_rem_q - WORD_BYTES;
            st_q <= IDE_IN_STEP;
          end
        end
        IDE_DIG: begin
          // digest words leave the datapath one at a time
          if (!dp_dig) begin
            dp_dig <= 1'b1;
          end else if (dp_ack) begin
            dp_dig <= 1'b0;
            mem_we <= 1'b1;
            mem_req <= 1'b1;
            mem_addr <= out_next_q + {24'h0, wcnt_q, 2'h0};
            mem_wdata <= dp_rdata;
            st_q <= IDE_DIG_WR;
          end
        end
        IDE_DIG_WR: if (mem_ack) begin
          // full length digest, no truncation
          {mem_req, mem_we} <= '0;
          wcnt_q <= wcnt_q + 6'h1;
          st_q <= (wcnt_q == {3'h0, dig_words} - 6'h1) ? IDE_NEXT : IDE_DIG;
        end
        IDE_NEXT: begin
          // descriptors strictly in list order
          if (last_pkt) begin
            mem_we <= 1'b1;
            mem_req <= 1'b1;
            mem_addr <= hdr_addr_q;
            mem_wdata <= hdr_out;
            st_q <= IDE_HDR_WR;
          end else begin
            pkt_idx_q <= pkt_idx_q + 16'h1;
            desc_addr_q <= desc_addr_q + DESC_BYTES;
            mem_addr <= desc_addr_q + DESC_BYTES;
            mem_req <= 1'b1;
            wcnt_q <= '0;
            st_q <= IDE_DESC_RD;
          end
        end
        IDE_HDR_WR: if (mem_ack) begin
          {mem_req, mem_we} <= '0;
          rec_done <= 1'b1;
          st_q <= IDE_IDLE;
        end
        default: st_q <= IDE_IDLE;
      endcase
    end
  end

  // busy is registered so the output stays a flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) busy <= 1'b0;
    else busy <= (st_q != IDE_IDLE);
  end
endmodule : ide_engine

// ==== rtl/ide_op_decode.sv ====
// opcode and flag decoder for one command context
// assumes opcode and flags are stable registers of the caller
module ide_op_decode
  import ide_pkg::*;
(
  input wire logic asym, // record came through the asymmetric queue
  input wire logic [7:0] opcode,
  input wire logic [15:0] flags,
  output logic [1:0] op_class,
  output logic cipher_en,
  output logic inbound,
  output logic [1:0] auth_sel
);
  // asymmetric map leaves 0x00, 0x07..0x40, 0x48 and codes past 0x49 reserved
  wire asym_ok = ((opcode >= OP_ASY_FIRST) && (opcode <= OP_ASY_LAST_LOW)) ||
                 ((opcode >= OP_ASY_FIRST_HI) && (opcode <= OP_ASY_MODEXP)) ||
                 (opcode == OP_ASY_DBLEXP);
  // symmetric ops other than the des one
  wire sym_other = ((opcode > OP_IPSEC_DES) && (opcode <= OP_SYM_LAST_LOW)) ||
                   (opcode == OP_HASH) || (opcode == OP_IPSEC_AES);
  // illegal flag combinations fail rather than move data
  wire flags_bad = (flags[FLG_AUTH_MSB:FLG_AUTH_LSB] == 2'h3) ||
                   (!flags[FLG_CIPHER_BIT] && (flags[FLG_AUTH_MSB:FLG_AUTH_LSB] == AUTH_NONE));
  wire is_des = !asym && (opcode == OP_IPSEC_DES);

  assign cipher_en = flags[FLG_CIPHER_BIT];
  assign inbound = flags[FLG_DIR_BIT];
  assign auth_sel = flags[FLG_AUTH_MSB:FLG_AUTH_LSB];
  assign op_class = is_des ? (flags_bad ? OPC_BAD : OPC_DES) :
                    ((asym ? asym_ok : sym_other) ? OPC_OTHER : OPC_BAD);
endmodule : ide_op_decode

// ==== rtl/ide_pkg.sv ====
// constants, encodings and state type shared by the command-record engine
// assumes one clock domain and word-wide host memory access through a dma front end
package ide_pkg;
  // command record header word fields
  localparam int HDR_NPKT_MSB = 15; // packet count field top bit
  localparam int HDR_DONE_BIT = 16; // completion flag
  localparam int HDR_ERR_BIT = 17; // error flag
  localparam int HDR_CODE_LSB = 28; // error code field low bit
  localparam logic [3:0] ERR_NONE = 4'h0; // normal completion
  localparam logic [3:0] ERR_OPCODE = 4'h1; // unknown opcode or illegal flags
  localparam logic [3:0] ERR_CHAIN = 4'h5; // input chain too short
  // symmetric queue opcodes
  localparam logic [7:0] OP_IPSEC_DES = 8'h00;
  localparam logic [7:0] OP_HASH = 8'h05;
  localparam logic [7:0] OP_IPSEC_AES = 8'h40;
  localparam logic [7:0] OP_SYM_LAST_LOW = 8'h05; // 0x01..0x05 are ssl/tls/hash ops
  // asymmetric queue opcodes
  localparam logic [7:0] OP_ASY_FIRST = 8'h01; // key pair generation
  localparam logic [7:0] OP_ASY_LAST_LOW = 8'h06; // dsa verification
  localparam logic [7:0] OP_ASY_FIRST_HI = 8'h41; // rng direct
  localparam logic [7:0] OP_ASY_MODEXP = 8'h47; // modular exponentiation
  localparam logic [7:0] OP_ASY_DBLEXP = 8'h49; // double modular exponentiation
  // flag word fields
  localparam int FLG_CIPHER_BIT = 15;
  localparam int FLG_DIR_BIT = 14;
  localparam int FLG_AUTH_MSB = 13;
  localparam int FLG_AUTH_LSB = 12;
  localparam logic [1:0] AUTH_NONE = 2'h0;
  localparam logic [1:0] AUTH_MD5 = 2'h1;
  localparam logic [1:0] AUTH_SHA1 = 2'h2;
  // decoded operation classes
  localparam logic [1:0] OPC_BAD = 2'h0; // undefined or illegal
  localparam logic [1:0] OPC_DES = 2'h1; // executed here
  localparam logic [1:0] OPC_OTHER = 2'h2; // valid, handled by another unit
  // structure sizes
  localparam logic [3:0] DESC_WORDS = 4'h8; // 32 byte packet descriptor
  localparam logic [31:0] DESC_BYTES = 32'h0000_0020;
  localparam logic [3:0] CHAIN_WORDS = 4'h3; // address, next, length
  localparam logic [15:0] CTX_MIN_BYTES = 16'h0040; // least context fetch
  localparam logic [2:0] DIG_WORDS_MD5 = 3'h4; // 16 byte digest
  localparam logic [2:0] DIG_WORDS_SHA = 3'h5; // 20 byte digest
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  // descriptor word indices
  localparam logic [3:0] DW_CTX = 4'h0, DW_IN_ADDR = 4'h1, DW_IN_NEXT = 4'h2, DW_IN_LEN = 4'h3;
  localparam logic [3:0] DW_OUT_ADDR = 4'h4, DW_OUT_NEXT = 4'h5, DW_OUT_LEN = 4'h6, DW_PKT_LEN = 4'h7;
  // chain entry word indices
  localparam logic [3:0] CW_ADDR = 4'h0, CW_NEXT = 4'h1, CW_LEN = 4'h2;
  // context word indices
  localparam logic [5:0] XW_HEAD = 6'h00, XW_FLAGS = 6'h01;

  typedef enum logic [3:0] {
    IDE_IDLE = 4'b0000,
    IDE_HDR_RD = 4'b0001,
    IDE_DESC_RD = 4'b0010,
    IDE_CTX_RD = 4'b0011,
    IDE_DECIDE = 4'b0100,
    IDE_IN_STEP = 4'b0101,
    IDE_IN_CHAIN = 4'b0110,
    IDE_IN_RD = 4'b0111,
    IDE_DP_WAIT = 4'b1000,
    IDE_OUT_CHAIN = 4'b1001,
    IDE_OUT_WR = 4'b1010,
    IDE_DIG = 4'b1011,
    IDE_DIG_WR = 4'b1100,
    IDE_NEXT = 4'b1101,
    IDE_HDR_WR = 4'b1110
  } ide_state_t;
endpackage : ide_pkg
